// [rtl/tsca_chan.sv]
// One limit comparator channel with alert and therm modes.
// Assumes upd is a one-cycle strobe with a valid temperature result.
`timescale 1ns/100ps
module tsca_chan
  import tsca_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Channel bundle.
  tsca_chan_if.chan ch
);

  logic high_q;
  logic low_q;
  logic above;
  logic below;

  // Comparisons are strict, so a result equal to a limit sets nothing.
  assign above = ch.temp > ch.hi_lim;
  assign below = ch.temp < ch.lo_lim;

  // High flag: sticky window in alert mode, hysteresis in therm mode.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      high_q <= 1'b0;
    else if (ch.mode)
    begin
      if (ch.upd && above)
        high_q <= 1'b1;                    // [R11] [R17]
      else if (ch.upd && below)
        high_q <= 1'b0;                    // [R11] [R12]
    end
    else if (ch.upd && above)
      high_q <= 1'b1;                      // [R07] [R09] [R15]
    else if (ch.rd_clr)
      high_q <= 1'b0;                      // [R10]
  end

  // Low flag: alert mode only; a set in the read cycle wins the clear.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      low_q <= 1'b0;
    else if (ch.mode)
      low_q <= 1'b0;                       // [R13] [R16]
    else if (ch.upd && below)
      low_q <= 1'b1;                       // [R08] [R09] [R16]
    else if (ch.rd_clr)
      low_q <= 1'b0;                       // [R10]
  end

  // The low flag is hidden at once when the channel enters therm mode.
  assign ch.high_flag = high_q;
  assign ch.low_flag  = low_q & ~ch.mode;  // [R13] [R16]

  // One clock and one reset serve every check of this channel.
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  exceed_sets_a: assert property (ch.upd && above |=> high_q) // [R07]
    else $error("high flag not set on exceeded limit");
  alert_sticky_a: assert property (                        // [R10]
    !ch.mode && high_q && !ch.rd_clr ##1 !ch.mode |-> high_q)
    else $error("alert flag dropped without a read");
  therm_keep_a: assert property (                          // [R12]
    ch.mode && high_q && !ch.upd ##1 ch.mode |-> high_q)
    else $error("therm flag changed outside a conversion end");
  therm_low_a: assert property (ch.mode ##1 ch.mode |-> !low_q) // [R13]
    else $error("low flag kept in therm mode");
  read_clear_a: assert property (                          // [R10]
    !ch.mode && ch.rd_clr && !ch.upd ##1 !ch.mode |-> !high_q && !low_q)
    else $error("alert flags not cleared by read");
endmodule

// [rtl/tsca_chan_if.sv]
// Bundle between the top module and one limit comparator channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tsca_chan_if;
  import tsca_pkg::*;
  tsca_temp_t temp;
  tsca_temp_t hi_lim;
  tsca_temp_t lo_lim;
  logic       mode;
  logic       upd;
  logic       rd_clr;
  logic       high_flag;
  logic       low_flag;

  modport top  (output temp, hi_lim, lo_lim, mode, upd, rd_clr,
                input  high_flag, low_flag);
  modport chan (input  temp, hi_lim, lo_lim, mode, upd, rd_clr,
                output high_flag, low_flag);
endinterface

// [rtl/tsca_defines.svh]
// Field positions, reset values and timing figures of the
// temperature sensor configuration and alert block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef TSCA_DEFINES_SVH
`define TSCA_DEFINES_SVH

// Field positions in the configuration word.
`define TSCA_RATE_HI   15
`define TSCA_RATE_LO   13
`define TSCA_TRIG_BIT  12
`define TSCA_SD_BIT    11
`define TSCA_FH1_BIT   10
`define TSCA_FL1_BIT   9
`define TSCA_M1_BIT    8
`define TSCA_CH_ONE_OUT_POLARITY_BIT  7
`define TSCA_FH2_BIT   6
`define TSCA_FL2_BIT   5
`define TSCA_M2_BIT    4
`define TSCA_CH_TWO_OUT_POLARITY_BIT  3

// Reset value of the conversion rate field.
`define TSCA_RATE_RST  3'h5

// Conversion periods in milliseconds, one per rate code.
`define TSCA_PER0_MS   15
`define TSCA_PER1_MS   50
`define TSCA_PER2_MS   100
`define TSCA_PER3_MS   250
`define TSCA_PER4_MS   500
`define TSCA_PER5_MS   1000
`define TSCA_PER6_MS   4000
`define TSCA_PER7_MS   16000

// Clock rate in kHz, equal to clock cycles per millisecond.
`define TSCA_CLK_KHZ   125000

`endif

// [rtl/tsca_pkg.sv]
// Types shared by the configuration and alert block.
// Assumes the defines header is on the include path.
package tsca_pkg;
  `include "tsca_defines.svh"

  // Conversion sequencer states; code 2'b11 is unused.
  typedef enum logic [1:0]
  {
    TSCA_SHUT = 2'b00,
    TSCA_CONV = 2'b01,
    TSCA_WAIT = 2'b10
  } tsca_state_t;

  // Signed temperature result and limit value.
  typedef logic signed [13:0] tsca_temp_t;
endpackage

// [rtl/tsca_top.sv]
// Configuration word, conversion sequencer and two alert channels.
// Assumes the converter returns conv_done on this clock after conv_start.
//
// Contract
// (R01) Rate field in bits 15..13 selects the update period, reset value five.
// (R02) Rate applies only to continuous conversion, never to a single one.
// (R03) Trigger bit 12 written one in shutdown starts exactly one conversion.
// (R04) After the single conversion completes, return to shutdown.
// (R05) The trigger bit always reads zero.
// (R06) Bit 11 zero means continuous, one means shutdown.
// (R07) Channel one high flag, bit 10, shows result above high limit one.
// (R08) Alert mode: channel one low flag, bit 9, shows result below low one.
// (R09) Channel one mode zero: limits form a window raising high or low flag.
// (R10) Alert mode flags stay set until a configuration read clears them.
// (R11) Therm mode: high flag sets above high limit, clears below low limit.
// (R12) Therm mode flags change only at conversion end; reads do not clear.
// (R13) Therm mode: channel one low flag unused, reads zero.
// (R14) Bit 7 sets channel one alert pin active low (0) or high (1).
// (R15) Channel two high flag, bit 6, shows result above high limit two.
// (R16) Channel two low flag, bit 5, alert mode below low two, else zero.
// (R17) Bit 4 selects channel two mode; same behaviour with limit pair two.
// (R18) Rate codes 0..7 mean 15,50,100,250,500 ms, 1 s, 4 s, 16 s.
// (R19) Any write aborts the conversion and acts on new settings at once.
// (R20) Bit 3 sets channel two alert pin active low (0) or high (1).
// (R21) Alert pin is active while either flag of its channel is set.
// (R22) Trigger written during continuous conversion changes nothing else.
`timescale 1ns/100ps
`include "tsca_defines.svh"
module tsca_top
  import tsca_pkg::*;
#(
  parameter int unsigned CLK_KHZ = `TSCA_CLK_KHZ
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Configuration word access.
  input  wire logic        cfg_wr_en,
  input  wire logic [15:0] cfg_wr_data,
  input  wire logic        cfg_rd_en,
  output logic      [15:0] cfg_rd_data_q,
  // Converter handshake.
  output logic             conv_start_q,
  output logic             conv_abort_q,
  input  wire logic        conv_done,
  input  wire tsca_temp_t  temp_result,
  // Limits held elsewhere.
  input  wire tsca_temp_t  high_lim_one,
  input  wire tsca_temp_t  low_lim_one,
  input  wire tsca_temp_t  high_lim_two,
  input  wire tsca_temp_t  low_lim_two,
  // Alert pins.
  output logic             ch_one_alert_out_q,
  output logic             ch_two_alert_out_q
);

  tsca_state_t state_q;
  tsca_state_t state_d;
  logic [2:0]  conv_rate_sel_q;
  logic        shutdown_select_q;
  logic        ch_one_mode_sel_q;
  logic        ch_one_out_polarity_q;
  logic        ch_two_mode_sel_q;
  logic        ch_two_out_polarity_q;
  logic [31:0] per_cnt_q;
  logic [31:0] per_cnt_d;
  logic        launch;
  logic        done_ok;
  logic [2:0]  rate_new;
  logic        wr_sd;
  logic        wr_trig;
  logic        ch_one_any;
  logic        ch_two_any;

  tsca_chan_if one_if ();
  tsca_chan_if two_if ();

  // Period in cycles for a rate code; a product of ms and kHz.
  function automatic logic [31:0] per_cycles(input logic [2:0] rate);
    logic [31:0] ms;
    ms = 32'h0;
    unique case (rate)                     // [R18]
      3'h0: ms = 32'(`TSCA_PER0_MS);
      3'h1: ms = 32'(`TSCA_PER1_MS);
      3'h2: ms = 32'(`TSCA_PER2_MS);
      3'h3: ms = 32'(`TSCA_PER3_MS);
      3'h4: ms = 32'(`TSCA_PER4_MS);
      3'h5: ms = 32'(`TSCA_PER5_MS);
      3'h6: ms = 32'(`TSCA_PER6_MS);
      3'h7: ms = 32'(`TSCA_PER7_MS);
    endcase
    return 32'(ms * CLK_KHZ);
  endfunction

  // Fields of an incoming write.
  assign wr_sd    = cfg_wr_data[`TSCA_SD_BIT];
  assign wr_trig  = cfg_wr_data[`TSCA_TRIG_BIT];
  assign rate_new = cfg_wr_en ? cfg_wr_data[`TSCA_RATE_HI:`TSCA_RATE_LO]
                              : conv_rate_sel_q;

  // A result is taken only for a live conversion; a write kills it.
  assign done_ok = conv_done && (state_q == TSCA_CONV) && !cfg_wr_en; // [R19]

  // Writable configuration fields; the trigger bit is never stored.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      conv_rate_sel_q       <= `TSCA_RATE_RST; // [R01]
      shutdown_select_q     <= 1'b0;
      ch_one_mode_sel_q     <= 1'b0;
      ch_one_out_polarity_q <= 1'b0;
      ch_two_mode_sel_q     <= 1'b0;
      ch_two_out_polarity_q <= 1'b0;
    end
    else if (cfg_wr_en)
    begin
      conv_rate_sel_q       <= cfg_wr_data[`TSCA_RATE_HI:`TSCA_RATE_LO];
      shutdown_select_q     <= wr_sd;      // [R06]
      ch_one_mode_sel_q     <= cfg_wr_data[`TSCA_M1_BIT];   // [R09]
      ch_one_out_polarity_q <= cfg_wr_data[`TSCA_CH_ONE_OUT_POLARITY_BIT]; // [R14]
      ch_two_mode_sel_q     <= cfg_wr_data[`TSCA_M2_BIT];   // [R17]
      ch_two_out_polarity_q <= cfg_wr_data[`TSCA_CH_TWO_OUT_POLARITY_BIT]; // [R20]
    end
  end

  // Start decision: a continuous or trigger write restarts at once, otherwise the period timer.
  always_comb
  begin
    launch = 1'b0;
    if (cfg_wr_en)
      launch = wr_sd ? wr_trig : 1'b1;     // [R03] [R19] [R22]
    else if (state_q == TSCA_WAIT)
      launch = (per_cnt_q == 32'h0);       // [R02]
    else if (done_ok && !shutdown_select_q)
      launch = (per_cnt_q == 32'h0);
  end

  // Next state of the conversion sequencer.
  always_comb
  begin
    state_d = state_q;
    if (launch)
      state_d = TSCA_CONV;
    else if (cfg_wr_en)
      state_d = TSCA_SHUT;                 // [R06] [R19]
    else
    begin
      unique case (state_q)
        TSCA_SHUT: state_d = TSCA_SHUT;
        TSCA_WAIT: state_d = TSCA_WAIT;
        TSCA_CONV:
          if (done_ok)
            state_d = shutdown_select_q ? TSCA_SHUT : TSCA_WAIT; // [R04]
        default:   state_d = TSCA_SHUT;
      endcase
    end
  end

  // Sequencer register; reset waits on an expired timer so the first
  // continuous conversion starts one cycle after release.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_q <= TSCA_WAIT;
    else
      state_q <= state_d;
  end

  // Period timer counts from each conversion start; single shots skip it.
  // The longest period at 125 MHz is 2e9 cycles, still inside 32 bits.
  always_comb
  begin
    per_cnt_d = per_cnt_q;
    if (launch && !(cfg_wr_en ? wr_sd : shutdown_select_q))
      per_cnt_d = per_cycles(rate_new) - 32'h1; // [R01] [R02]
    else if (per_cnt_q != 32'h0)
      per_cnt_d = per_cnt_q - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      per_cnt_q <= 32'h0;
    else
      per_cnt_q <= per_cnt_d;
  end

  // Converter strobes.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      conv_start_q <= 1'b0;
      conv_abort_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= launch;
      conv_abort_q <= cfg_wr_en && (state_q == TSCA_CONV); // [R19]
    end
  end

  // Channel bundles.
  assign one_if.temp   = temp_result;
  assign one_if.hi_lim = high_lim_one;
  assign one_if.lo_lim = low_lim_one;
  assign one_if.mode   = ch_one_mode_sel_q;
  assign one_if.upd    = done_ok;
  assign one_if.rd_clr = cfg_rd_en;
  assign two_if.temp   = temp_result;
  assign two_if.hi_lim = high_lim_two;
  assign two_if.lo_lim = low_lim_two;
  assign two_if.mode   = ch_two_mode_sel_q;
  assign two_if.upd    = done_ok;
  assign two_if.rd_clr = cfg_rd_en;

  tsca_chan u_ch_one (
    .clk   (clk),
    .rst_b (rst_b),
    .ch    (one_if)
  );

  tsca_chan u_ch_two (
    .clk   (clk),
    .rst_b (rst_b),
    .ch    (two_if)
  );

  // Read data is captured before the same edge clears alert flags.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cfg_rd_data_q <= 16'h0;
    else if (cfg_rd_en)
    begin
      cfg_rd_data_q                              <= 16'h0;
      cfg_rd_data_q[`TSCA_RATE_HI:`TSCA_RATE_LO] <= conv_rate_sel_q;
      cfg_rd_data_q[`TSCA_TRIG_BIT]              <= 1'b0; // [R05]
      cfg_rd_data_q[`TSCA_SD_BIT]                <= shutdown_select_q;
      cfg_rd_data_q[`TSCA_FH1_BIT]               <= one_if.high_flag;
      cfg_rd_data_q[`TSCA_FL1_BIT]               <= one_if.low_flag;
      cfg_rd_data_q[`TSCA_M1_BIT]                <= ch_one_mode_sel_q;
      cfg_rd_data_q[`TSCA_CH_ONE_OUT_POLARITY_BIT]              <= ch_one_out_polarity_q;
      cfg_rd_data_q[`TSCA_FH2_BIT]               <= two_if.high_flag;
      cfg_rd_data_q[`TSCA_FL2_BIT]               <= two_if.low_flag;
      cfg_rd_data_q[`TSCA_M2_BIT]                <= ch_two_mode_sel_q;
      cfg_rd_data_q[`TSCA_CH_TWO_OUT_POLARITY_BIT]              <= ch_two_out_polarity_q;
    end
  end

  // Alert pins follow the flags one cycle late; reset drives them high.
  assign ch_one_any = one_if.high_flag | one_if.low_flag;
  assign ch_two_any = two_if.high_flag | two_if.low_flag;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ch_one_alert_out_q <= 1'b1;
      ch_two_alert_out_q <= 1'b1;
    end
    else
    begin
      ch_one_alert_out_q <= ch_one_any ~^ ch_one_out_polarity_q; // [R14] [R21]
      ch_two_alert_out_q <= ch_two_any ~^ ch_two_out_polarity_q; // [R20] [R21]
    end
  end

  // Sequencer and configuration checks. A write may legally follow any
  // conversion end, so checks that look two cycles ahead exempt it.
  rate_reset_a: assert property (@(posedge clk)           // [R01]
    !rst_b |=> conv_rate_sel_q == 3'h5)
    else $error("rate field not five after reset");
  single_start_a: assert property (@(posedge clk)         // [R03]
    disable iff (!rst_b)
    cfg_wr_en && wr_sd && wr_trig |=> conv_start_q && state_q == TSCA_CONV)
    else $error("single conversion not started");
  shut_write_a: assert property (@(posedge clk)           // [R06]
    disable iff (!rst_b)
    cfg_wr_en && wr_sd && !wr_trig |=> !conv_start_q
      && state_q == TSCA_SHUT)
    else $error("shutdown write did not stop conversions");
  single_end_a: assert property (@(posedge clk)           // [R04]
    disable iff (!rst_b)
    done_ok && shutdown_select_q |=> state_q == TSCA_SHUT
      ##1 (!conv_start_q || $past(cfg_wr_en)))
    else $error("single conversion did not return to shutdown");
  trig_zero_a: assert property (@(posedge clk)            // [R05]
    disable iff (!rst_b)
    cfg_rd_en |=> !cfg_rd_data_q[`TSCA_TRIG_BIT])
    else $error("trigger bit read as one");
  write_abort_a: assert property (@(posedge clk)          // [R19]
    disable iff (!rst_b)
    cfg_wr_en && state_q == TSCA_CONV |=> conv_abort_q)
    else $error("write did not abort conversion");
  abort_cause_a: assert property (@(posedge clk)          // [R19]
    disable iff (!rst_b)
    conv_abort_q |-> $past(cfg_wr_en) && $past(state_q) == TSCA_CONV)
    else $error("abort without a write during a conversion");
  cont_restart_a: assert property (@(posedge clk)         // [R19]
    disable iff (!rst_b)
    cfg_wr_en && !wr_sd |=> conv_start_q
      && per_cnt_q == $past(per_cycles(rate_new)) - 32'h1)
    else $error("continuous write did not restart at new rate");
  trig_cont_a: assert property (@(posedge clk)            // [R22]
    disable iff (!rst_b)
    cfg_wr_en && !wr_sd && wr_trig |=> !shutdown_select_q
      && state_q == TSCA_CONV)
    else $error("trigger in continuous mode changed the mode");
  wait_launch_a: assert property (@(posedge clk)          // [R02]
    disable iff (!rst_b)
    state_q == TSCA_WAIT && per_cnt_q == 32'h0 && !cfg_wr_en
      |=> conv_start_q && state_q == TSCA_CONV)
    else $error("expired period did not start a conversion");
  single_timer_a: assert property (@(posedge clk)         // [R02]
    disable iff (!rst_b)
    cfg_wr_en && wr_sd && per_cnt_q == 32'h0 |=> per_cnt_q == 32'h0)
    else $error("single conversion loaded the period timer");
  pin_polarity_a: assert property (@(posedge clk)         // [R21]
    disable iff (!rst_b)
    ##1 ch_one_alert_out_q == ($past(ch_one_any)
      ~^ $past(ch_one_out_polarity_q)))
    else $error("alert pin one level wrong");
  pin_two_a: assert property (@(posedge clk)              // [R20]
    disable iff (!rst_b)
    ##1 ch_two_alert_out_q == ($past(ch_two_any)
      ~^ $past(ch_two_out_polarity_q)))
    else $error("alert pin two level wrong");

  // Main scenarios: single shot, continuous restart, read clear, therm
  // release below the low limit, and a write that aborts a conversion.
  single_cov: cover property (@(posedge clk) disable iff (!rst_b)
    cfg_wr_en && wr_sd && wr_trig ##[1:50] done_ok);
  cont_cov: cover property (@(posedge clk) disable iff (!rst_b)
    done_ok && !shutdown_select_q ##[1:100] conv_start_q);
  clear_cov: cover property (@(posedge clk) disable iff (!rst_b)
    one_if.high_flag && !ch_one_mode_sel_q && cfg_rd_en ##1
      !one_if.high_flag);
  therm_cov: cover property (@(posedge clk) disable iff (!rst_b)
    two_if.high_flag && ch_two_mode_sel_q && done_ok ##1 !two_if.high_flag);
  abort_cov: cover property (@(posedge clk) disable iff (!rst_b)
    conv_abort_q && conv_start_q);
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the configuration word and the two alert channels.
// Assumes tsca_top runs with CLK_KHZ of 1, so a period in ms is in cycles.
`timescale 1ns/100ps
module tb_top;
  import tsca_pkg::*;
  // Design ports and bench state.
  logic        clk;
  logic        rst_b;
  logic        cfg_wr_en;
  logic [15:0] cfg_wr_data;
  logic        cfg_rd_en;
  logic [15:0] cfg_rd_data_q;
  logic        conv_start_q;
  logic        conv_abort_q;
  logic        conv_done;
  tsca_temp_t  temp_result;
  tsca_temp_t  lim[4];
  logic        ch_one_alert_out;
  logic        ch_two_alert_out;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] lfsr;
  logic [15:0] cfg;
  logic [15:0] exp_q[$];
  // Conversion periods per rate code and the flag scenario table.
  int          per[8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};
  logic [15:0] tc[11] = '{16'h0800, 16'h0800, 16'h0800, 16'h0800,
                          16'h0888, 16'h0888, 16'h0888, 16'h0888,
                          16'h0910, 16'h0910, 16'h0910};
  int          tv[11] = '{101, -150, 201, -250, 101, -150, 201, -250,
                          250, 0, -250};
  logic [15:0] tf[11] = '{16'h0400, 16'h0200, 16'h0440, 16'h0220,
                          16'h0400, 16'h0200, 16'h0440, 16'h0220,
                          16'h0440, 16'h0440, 16'h0000};

  tsca_top #(.CLK_KHZ(1)) u_dut (
    .clk(clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_en(cfg_rd_en),
    .cfg_rd_data_q(cfg_rd_data_q), .conv_start_q(conv_start_q),
    .conv_abort_q(conv_abort_q), .conv_done(conv_done),
    .temp_result(temp_result), .high_lim_one(lim[0]),
    .low_lim_one(lim[1]), .high_lim_two(lim[2]), .low_lim_two(lim[3]),
    .ch_one_alert_out_q(ch_one_alert_out), .ch_two_alert_out_q(ch_two_alert_out));

  // Free running 8 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic fail(input string msg);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask

  task automatic cmp_int(input int got, input int exp, input string m);
    checks++;
    if (got != exp) fail($sformatf("%s got %0d want %0d", m, got, exp));
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("read %h want %h", got, exp));
  endtask

  task automatic stop_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [15:0] d);
    cfg_wr_en = 1'b1;
    cfg_wr_data = d;
    tick;
    cfg_wr_en = 1'b0;
  endtask

  // The extra edge keeps back to back reads from re-driving the strobe.
  task automatic rd(input logic [15:0] e);
    exp_q.push_back(e);
    cfg_rd_en = 1'b1;
    tick;
    cfg_rd_en = 1'b0;
    tick;
  endtask

  task automatic wait_start(output int c);
    c = 0;
    while (conv_start_q !== 1'b1 && c < 20000)
    begin
      tick;
      c++;
    end
    if (c >= 20000) fail("no conversion start");
  endtask

  // Converter answers at once when a start appears.
  task automatic conv(input tsca_temp_t t);
    int c;
    wait_start(c);
    conv_done = 1'b1;
    temp_result = t;
    tick;
    conv_done = 1'b0;
    temp_result = tsca_temp_t'(lfsr[13:0]);
  endtask

  task automatic quiet(output int c);
    c = 0;
    repeat (40)
    begin
      tick;
      if (conv_start_q === 1'b1) c++;
    end
  endtask

  // Read monitor: compares each read word against the oldest note.
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (cfg_rd_en === 1'b1)
      begin
        @(negedge clk);
        if (exp_q.size() == 0) fail("unexpected read");
        else cmp_word(cfg_rd_data_q, exp_q.pop_front());
      end
    end
  end

  // Hang guard, well above the longest expected run.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail("timeout");
      stop_test;
    end
  end

  initial
  begin
    rst_b = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_wr_data = 16'h0;
    cfg_rd_en = 1'b0;
    conv_done = 1'b0;
    temp_result = 14'sh0;
    lim = '{14'sd100, -14'sd100, 14'sd200, -14'sd200};
    lfsr = 32'hbb30;
    repeat (4) tick;
    cmp_bit(ch_one_alert_out, 1'b1, "reset pin one");
    cmp_bit(ch_two_alert_out, 1'b1, "reset pin two");
    rst_b = 1'b1;
    rd(16'ha000);
    $display("test reset done");
    // Every rate code: period between starts in continuous mode.
    for (int r = 0; r < 8; r++)
    begin
      wr({3'(r), 13'h0});
      conv(tsca_temp_t'(lfsr[5:0]));
      lfsr = lfsr_next(lfsr);
      wait_start(n);
      cmp_int(n, per[r] - 1, "period");
      rd({3'(r), 13'h0});
    end
    $display("test rates done");
    wr(16'h0000);
    tick;
    wr(16'h1000);
    cmp_bit(conv_abort_q, 1'b1, "abort");
    cmp_bit(conv_start_q, 1'b1, "restart");
    rd(16'h0000);
    tick;
    wr(16'h0800);
    cmp_bit(conv_abort_q, 1'b1, "abort to shutdown");
    quiet(n);
    cmp_int(n, 0, "start in shutdown");
    $display("test abort done");
    // Single shots through alert, polarity and therm cases.
    for (int i = 0; i < 11; i++)
    begin
      cfg = tc[i];
      wr(cfg | 16'h1800);
      conv(tsca_temp_t'(tv[i] + int'(lfsr[4:0])));
      lfsr = lfsr_next(lfsr);
      quiet(n);
      cmp_int(n, 0, "extra conversion");
      cmp_bit(ch_one_alert_out, (|tf[i][10:9]) ~^ cfg[7], "pin one");
      cmp_bit(ch_two_alert_out, (|tf[i][6:5]) ~^ cfg[3], "pin two");
      rd((cfg & 16'he998) | tf[i]);
      rd((cfg & 16'he998) | (cfg[8] ? tf[i] : 16'h0));
      cmp_bit(ch_one_alert_out, (cfg[8] & tf[i][10]) ~^ cfg[7], "pin one");
      cmp_bit(ch_two_alert_out, (cfg[4] & tf[i][6]) ~^ cfg[3], "pin two");
    end
    $display("test flags done");
    // A second reset mid-run must bring the rate field back to five.
    rst_b = 1'b0;
    repeat (2) tick;
    cmp_bit(ch_one_alert_out, 1'b1, "reset pin one again");
    rst_b = 1'b1;
    rd(16'ha000);
    $display("test second reset done");
    repeat (3) tick;
    cmp_int(exp_q.size(), 0, "reads left");
    stop_test;
  end
endmodule
